// ### rtl/tmw_pkg.sv
// package: register map, field layout and mode codes for the 8-bit waveform timer
package tmw_pkg;
	// ****************************************
	// register offsets (word addresses)
	// ****************************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_COUNT = 4'h1;
	localparam logic [3:0] ADDR_CMP_A = 4'h2;
	localparam logic [3:0] ADDR_CMP_B = 4'h3;
	localparam logic [3:0] ADDR_FLAGS = 4'h4;
	// ****************************************
	// control field positions
	// ****************************************
	localparam int CTRL_WGM_LO = 0;
	localparam int CTRL_CS_LO = 4;
	localparam int CTRL_ACT_B_LO = 8;
	localparam int CTRL_ACT_A_LO = 10;
	localparam int FLAG_OVF = 0;
	localparam int FLAG_MA = 1;
	localparam int FLAG_MB = 2;
	// ****************************************
	// reset values and mode codes
	// ****************************************
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [2:0] WGM_NORMAL = 3'h0;
	localparam logic [2:0] WGM_PC_FF = 3'h1;
	localparam logic [2:0] WGM_CTC = 3'h2;
	localparam logic [2:0] WGM_FAST_FF = 3'h3;
	localparam logic [2:0] WGM_PC_OCA = 3'h5;
	localparam logic [2:0] WGM_FAST_OCA = 3'h7;
	localparam logic [1:0] ACT_OFF = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	// prescale select: 0 stop, 1..5 = /1,/8,/64,/256,/1024
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [9:0] PRE_MASK8 = 10'h007;
	localparam logic [9:0] PRE_MASK64 = 10'h03F;
	localparam logic [9:0] PRE_MASK256 = 10'h0FF;
	localparam logic [9:0] PRE_MASK1024 = 10'h3FF;
endpackage : tmw_pkg

// ### rtl/tmw_timer.sv
// design: 8-bit timer with normal, clear-on-match, fast and phase-correct waveform modes
`timescale 1ns/10ps
// Function
// - mode 0: count up, wrap FF to 00
// - normal mode: overflow flag set at zero
// - normal mode: counter writes accepted anytime
// - mode 2: clear counter on compare A
// - mode 2: match flag A at TOP
// - mode 2: compare A unbuffered, misses wrap
// - mode 2: action 1 toggles output A
// - prescale 1, 8, 64, 256, 1024
// - mode 2: overflow flag on MAX wrap
// - fast PWM single slope, TOP by mode
// - fast PWM clears cycle after TOP
// - fast PWM overflow flag at TOP
// - fast PWM clear/set on match, BOTTOM
// - PWM toggle A only with mode bit2
// - fast PWM extreme compare values
// - fast PWM compare always double buffered
// - phase correct up/down, TOP by mode
// - phase correct turns at TOP without holding
// - phase correct overflow flag at BOTTOM
// - phase correct: clear up, set down
// - phase correct extreme compare values
// - phase correct symmetry change at BOTTOM
// - match flag set next timer cycle
// - PWM compare updates at TOP
module tmw_timer import tmw_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// interrupt acknowledge pulses that auto-clear flags
	input wire logic ovf_ack,
	input wire logic match_a_ack,
	input wire logic match_b_ack,
	// waveform outputs
	output logic wave_out_a,
	output logic wave_out_b,
	output logic wave_en_a,
	output logic wave_en_b,
	output logic overflow_flag,
	output logic match_flag_a,
	output logic match_flag_b
);
	// ****************************************
	// reset release
	// ****************************************
	logic rst_s1_r, rst_s2_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire logic rst_i_n = rst_s2_r;

	// ****************************************
	// control register
	// ****************************************
	logic [31:0] ctrl_r;
	logic [2:0] wave_gen_select;
	logic [2:0] clk_sel;
	logic [1:0] out_action_a, out_action_b;
	logic wave_gen_select_hi;
	assign wave_gen_select = ctrl_r[CTRL_WGM_LO +: 3];
	assign wave_gen_select_hi = wave_gen_select[2];
	assign clk_sel = ctrl_r[CTRL_CS_LO +: 3];
	assign out_action_a = ctrl_r[CTRL_ACT_A_LO +: 2];
	assign out_action_b = ctrl_r[CTRL_ACT_B_LO +: 2];

	wire logic wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
	wire logic wr_cnt = reg_wr && reg_addr == ADDR_COUNT;
	wire logic wr_cmpa = reg_wr && reg_addr == ADDR_CMP_A;
	wire logic wr_cmpb = reg_wr && reg_addr == ADDR_CMP_B;
	wire logic wr_flag = reg_wr && reg_addr == ADDR_FLAGS;

	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			ctrl_r <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= {20'h00000, reg_wdata[11:0]} & 32'h0000_0F77;
		end
	end

	// ****************************************
	// prescaler
	// ****************************************
	logic [9:0] pre_r;
	logic tick;
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			pre_r <= 10'h000;
		end else if (clk_sel == CS_STOP) begin
			pre_r <= 10'h000;
		end else begin
			pre_r <= pre_r + 10'h001;
		end
	end
	always_comb begin
		case (clk_sel)
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = (pre_r & PRE_MASK8) == PRE_MASK8;
			CS_DIV64: tick = (pre_r & PRE_MASK64) == PRE_MASK64;
			CS_DIV256: tick = (pre_r & PRE_MASK256) == PRE_MASK256;
			CS_DIV1024: tick = pre_r == PRE_MASK1024;
			default: tick = 1'b0;
		endcase
	end

	// ****************************************
	// mode decode and compare buffers
	// ****************************************
	logic is_pwm, is_fast, is_pc, is_ctc;
	assign is_fast = wave_gen_select[1:0] == WGM_FAST_FF[1:0];
	assign is_pc = wave_gen_select[1:0] == WGM_PC_FF[1:0];
	assign is_pwm = is_fast || is_pc;
	assign is_ctc = wave_gen_select == WGM_CTC;

	logic [7:0] count_value, compare_value_a, compare_value_b, buf_a_r, buf_b_r, top_val;
	logic cnt_down_r, blk_r;
	// mode 5/7 take compare A as TOP, all other PWM modes run to MAX
	assign top_val = (is_pwm && wave_gen_select_hi) ? compare_value_a : CNT_MAX;
	wire logic at_top = count_value == top_val;
	wire logic at_bot = count_value == CNT_BOTTOM;
	// active values load at TOP in both phase correct and fast PWM
	wire logic upd_pt = is_fast ? at_top : (at_top && !cnt_down_r);
	wire logic pwm_load = is_pwm && tick && upd_pt;

	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			buf_a_r <= CNT_BOTTOM;
			buf_b_r <= CNT_BOTTOM;
		end else begin
			if (wr_cmpa) begin
				buf_a_r <= reg_wdata[7:0];
			end
			if (wr_cmpb) begin
				buf_b_r <= reg_wdata[7:0];
			end
		end
	end

	// non-PWM modes write the active value directly
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			compare_value_a <= CNT_BOTTOM;
			compare_value_b <= CNT_BOTTOM;
		end else if (!is_pwm) begin
			if (wr_cmpa) begin
				compare_value_a <= reg_wdata[7:0];
			end
			if (wr_cmpb) begin
				compare_value_b <= reg_wdata[7:0];
			end
		end else if (pwm_load) begin
			compare_value_a <= buf_a_r;
			compare_value_b <= buf_b_r;
		end
	end

	// ****************************************
	// counter
	// ****************************************
	wire logic match_a = count_value == compare_value_a && !blk_r;
	wire logic match_b = count_value == compare_value_b && !blk_r;

	// a counter write blocks matches in the following timer cycle
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			blk_r <= 1'b0;
		end else if (wr_cnt) begin
			blk_r <= 1'b1;
		end else if (tick) begin
			blk_r <= 1'b0;
		end
	end

	// software write overrides any count or clear
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			count_value <= CNT_BOTTOM;
		end else if (wr_cnt) begin
			count_value <= reg_wdata[7:0];
		end else if (tick) begin
			if (is_ctc && count_value == compare_value_a) begin
				count_value <= CNT_BOTTOM;
			end else if (is_fast && at_top) begin
				count_value <= CNT_BOTTOM;
			end else if (is_pc && cnt_down_r) begin
				count_value <= at_bot ? count_value + 8'h01 : count_value - 8'h01;
			end else if (is_pc && at_top) begin
				count_value <= count_value - 8'h01;
			end else begin
				count_value <= count_value + 8'h01;
			end
		end
	end

	// phase correct direction turns at TOP and BOTTOM
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			cnt_down_r <= 1'b0;
		end else if (!is_pc) begin
			cnt_down_r <= 1'b0;
		end else if (tick) begin
			if (at_top && !at_bot) begin
				cnt_down_r <= 1'b1;
			end else if (at_bot) begin
				cnt_down_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// flags: hardware set wins over clear
	// ****************************************
	logic ovf_set;
	always_comb begin
		if (is_fast) begin
			ovf_set = tick && at_top;
		end else if (is_pc) begin
			ovf_set = tick && at_bot && cnt_down_r;
		end else begin
			ovf_set = tick && count_value == CNT_MAX && !(is_ctc && count_value == compare_value_a);
		end
	end
	logic ma_d_r, mb_d_r;
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			ma_d_r <= 1'b0;
			mb_d_r <= 1'b0;
		end else if (tick) begin
			ma_d_r <= match_a;
			mb_d_r <= match_b;
		end
	end
	// flag rises with the timer cycle after the match
	wire logic ma_set = tick && ma_d_r;
	wire logic mb_set = tick && mb_d_r;
	wire logic wc_ovf = wr_flag && reg_wdata[FLAG_OVF];
	wire logic wc_ma = wr_flag && reg_wdata[FLAG_MA];
	wire logic wc_mb = wr_flag && reg_wdata[FLAG_MB];
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			overflow_flag <= 1'b0;
			match_flag_a <= 1'b0;
			match_flag_b <= 1'b0;
		end else begin
			overflow_flag <= ovf_set | (overflow_flag & ~(ovf_ack | wc_ovf));
			match_flag_a <= ma_set | (match_flag_a & ~(match_a_ack | wc_ma));
			match_flag_b <= mb_set | (match_flag_b & ~(match_b_ack | wc_mb));
		end
	end

	// ****************************************
	// waveform generators
	// ****************************************
	function automatic logic wave_next(input logic cur, input logic [1:0] act, input logic tog_ok,
		input logic m, input logic [7:0] cmp, input logic [7:0] cnt, input logic dn, input logic tp,
		input logic bt);
		logic v;
		v = cur;
		if (!is_pwm) begin
			if (m) begin
				case (act)
					ACT_TOGGLE: v = ~cur;
					ACT_CLEAR: v = 1'b0;
					ACT_SET: v = 1'b1;
					default: v = cur;
				endcase
			end
		end else if (act == ACT_TOGGLE) begin
			if (tog_ok && m) begin
				v = ~cur;
			end
		end else if (act[1]) begin
			if (is_fast) begin
				// compare at TOP: match ignored, level taken at BOTTOM
				if (tp) begin
					v = ~act[0];
				end else if (m) begin
					v = act[0];
				end
			end else begin
				if (bt && dn) begin
					// symmetry around BOTTOM: compare at BOTTOM keeps the up-match level, else the down-match one
					v = (cmp == CNT_BOTTOM) ? act[0] : ~act[0];
				end else if (tp && cmp == cnt) begin
					v = ~act[0];
				end else if (m && !dn) begin
					v = act[0];
				end else if (m && dn) begin
					v = ~act[0];
				end
			end
		end
		return v;
	endfunction : wave_next

	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			wave_out_a <= 1'b0;
			wave_out_b <= 1'b0;
		end else if (tick) begin
			wave_out_a <= wave_next(wave_out_a, out_action_a, wave_gen_select_hi, match_a, compare_value_a,
				count_value, cnt_down_r, at_top, at_bot);
			wave_out_b <= wave_next(wave_out_b, out_action_b, 1'b0, match_b, compare_value_b,
				count_value, cnt_down_r, at_top, at_bot);
		end
	end
	assign wave_en_a = out_action_a != ACT_OFF && !(is_pwm && out_action_a == ACT_TOGGLE && !wave_gen_select_hi);
	assign wave_en_b = out_action_b != ACT_OFF && !(is_pwm && out_action_b == ACT_TOGGLE);

	// ****************************************
	// read port
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_CTRL: reg_rdata <= ctrl_r;
				ADDR_COUNT: reg_rdata <= {24'h000000, count_value};
				ADDR_CMP_A: reg_rdata <= {24'h000000, is_pwm ? buf_a_r : compare_value_a};
				ADDR_CMP_B: reg_rdata <= {24'h000000, is_pwm ? buf_b_r : compare_value_b};
				ADDR_FLAGS: reg_rdata <= {29'h0, match_flag_b, match_flag_a, overflow_flag};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	// a match on channel A whose previous timer cycle held none, so no older match is pending
	sequence s_fresh_match_a;
		tick && match_a && !match_flag_a && !ma_d_r;
	endsequence
	// one system cycle with no tick and nothing clearing the flag
	sequence s_quiet_cycle_a;
		(!tick && !match_a_ack && !wc_ma)[*1];
	endsequence
	a_normal_wrap: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		wave_gen_select == WGM_NORMAL && tick && count_value == CNT_MAX && !wr_cnt
		|=> count_value == CNT_BOTTOM && overflow_flag) else $error("normal wrap failed");
	a_ctc_clear: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		is_ctc && tick && count_value == compare_value_a && !wr_cnt && !wr_ctrl
		|=> count_value == CNT_BOTTOM) else $error("ctc clear failed");
	a_fast_top: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		is_fast && tick && at_top && !wr_cnt && !wr_ctrl |=> count_value == CNT_BOTTOM && overflow_flag)
		else $error("fast top failed");
	a_flag_delay: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		s_fresh_match_a ##1 s_quiet_cycle_a |-> !match_flag_a)
		else $error("match flag early");
	a_pc_dir: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		is_pc && tick && at_top && !at_bot && !wr_ctrl |=> cnt_down_r) else $error("pc turn failed");
	a_pc_ovf: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		is_pc && tick && at_bot && cnt_down_r |=> overflow_flag) else $error("pc overflow missed");
	a_pwm_buffer: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		is_pwm && !pwm_load && !wr_ctrl |=> $stable(compare_value_a)) else $error("buffer bypassed");
	a_flag_hold: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		overflow_flag && !ovf_ack && !wc_ovf |=> overflow_flag) else $error("flag lost");
	a_pc_bottom: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		is_pc && tick && at_bot && cnt_down_r && out_action_a == ACT_CLEAR
		|=> wave_out_a == ($past(compare_value_a) != CNT_BOTTOM)) else $error("pc bottom level wrong");
endmodule : tmw_timer

// ### test/tmw_testbench.sv
// testbench: register-port checks of the counting and waveform modes of the 8-bit timer
`timescale 1ns/10ps
module testbench import tmw_pkg::*;;
	// ****************************************
	// clock, reset and design ports
	// ****************************************
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ovf_ack = 1'b0;
	logic match_a_ack = 1'b0;
	logic match_b_ack = 1'b0;
	logic [31:0] reg_rdata;
	logic wave_out_a, wave_out_b, wave_en_a, wave_en_b;
	logic overflow_flag, match_flag_a, match_flag_b;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	logic [7:0] cv [0:2] = '{8'h00, 8'h40, 8'hFF};
	int fx [0:2] = '{2, 130, 512};
	int px [0:2] = '{0, 128, 510};
	int dv [0:4] = '{1, 8, 64, 256, 1024};
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	tmw_timer i_tmw_timer (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ovf_ack(ovf_ack), .match_a_ack(match_a_ack),
		.match_b_ack(match_b_ack), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .wave_en_a(wave_en_a),
		.wave_en_b(wave_en_b), .overflow_flag(overflow_flag), .match_flag_a(match_flag_a),
		.match_flag_b(match_flag_b));
	// ****************************************
	// access and compare tasks
	// ****************************************
	task automatic tally_and_finish();
		$display("mismatches=%0d compares=%0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// every access starts on a fresh edge so two strobes never collide in one step
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	function automatic logic [31:0] cw(input logic [2:0] m, input logic [2:0] cs, input logic [1:0] a,
		input logic [1:0] b);
		cw = CTRL_RESET;
		cw[CTRL_WGM_LO +: 3] = m;
		cw[CTRL_CS_LO +: 3] = cs;
		cw[CTRL_ACT_A_LO +: 2] = a;
		cw[CTRL_ACT_B_LO +: 2] = b;
	endfunction : cw
	task automatic prep(input logic [7:0] ca, input logic [7:0] cnt);
		wr(ADDR_CTRL, CTRL_RESET);
		wr(ADDR_CMP_A, {24'h0, ca});
		wr(ADDR_COUNT, {24'h0, cnt});
		wr(ADDR_FLAGS, 32'h0000_0007);
	endtask : prep
	// back-to-back counter reads; each value must follow from the one before
	task automatic cnt_seq(input logic [7:0] top, input logic dual);
		logic [7:0] v [0:39];
		logic dn;
		logic [7:0] e;
		dn = 1'b0;
		@(posedge clk_sys);
		reg_addr <= ADDR_COUNT;
		reg_rd <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_sys);
			#1 v[i] = reg_rdata;
		end
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		for (int i = 1; i < 40; i++) begin
			if (v[i-1] === top) dn = dual;
			if (v[i-1] === CNT_BOTTOM) dn = 1'b0;
			e = dn ? v[i-1] - 8'h01 : ((v[i-1] === top && !dual) ? CNT_BOTTOM : v[i-1] + 8'h01);
			chk({24'h0, v[i]}, {24'h0, e});
		end
	endtask : cnt_seq
	// cycles between two changes of output A, after aligning on a first change
	task automatic gap(output int n);
		logic w;
		@(posedge clk_sys);
		#1;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			w = wave_out_a;
			while (wave_out_a === w && n < 3000) begin
				@(posedge clk_sys);
				#1 n++;
			end
		end
	endtask : gap
	task automatic duty(input int n, output int ha, output int hb);
		ha = 0;
		hb = 0;
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			ha += (wave_out_a === 1'b1);
			hb += (wave_out_b === 1'b1);
		end
	endtask : duty
	task automatic ack_all();
		@(posedge clk_sys);
		{ovf_ack, match_a_ack, match_b_ack} <= 3'h7;
		@(posedge clk_sys);
		{ovf_ack, match_a_ack, match_b_ack} <= 3'h0;
		@(posedge clk_sys);
		#1;
	endtask : ack_all
	// ****************************************
	// hang guard
	// ****************************************
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [31:0] d;
		int n;
		int ha;
		int hb;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int a = 0; a < 5; a++) begin
			rd(a[3:0], d);
			chk(d, 32'h0000_0000);
		end
		wr(4'hF, 32'h0000_00A5);
		rd(4'hF, d);
		chk(d, 32'h0000_0000);
		wr(ADDR_CMP_B, 32'h0000_005A);
		rd(ADDR_CMP_B, d);
		chk(d, 32'h0000_005A);
		// normal: counter rewritten while running, then wraps
		prep(8'h00, 8'h00);
		wr(ADDR_CTRL, cw(WGM_NORMAL, CS_DIV1, ACT_OFF, ACT_OFF));
		wr(ADDR_COUNT, 32'h0000_00F0);
		cnt_seq(CNT_MAX, 1'b0);
		chk(overflow_flag, 1);
		// clear-on-match, started above the compare value so the first match is missed
		prep(8'h03, 8'hF0);
		wr(ADDR_CTRL, cw(WGM_CTC, CS_DIV1, ACT_OFF, ACT_OFF));
		cnt_seq(8'h03, 1'b0);
		chk(overflow_flag, 1);
		chk(match_flag_a, 1);
		prep(8'h06, 8'h00);
		wr(ADDR_CTRL, cw(WGM_FAST_OCA, CS_DIV1, ACT_OFF, ACT_OFF));
		cnt_seq(8'h06, 1'b0);
		chk(overflow_flag, 1);
		prep(8'h04, 8'h00);
		wr(ADDR_CTRL, cw(WGM_PC_OCA, CS_DIV1, ACT_OFF, ACT_OFF));
		cnt_seq(8'h04, 1'b1);
		chk(overflow_flag, 1);
		// toggle on every match with compare zero, through each prescale step
		for (int s = 0; s < 5; s++) begin
			prep(8'h00, 8'h00);
			wr(ADDR_CTRL, cw(WGM_CTC, CS_DIV1 + s[2:0], ACT_TOGGLE, ACT_OFF));
			gap(n);
			chk(n, dv[s]);
			chk(wave_en_a, 1);
		end
		prep(8'h03, 8'h00);
		wr(ADDR_CTRL, cw(WGM_FAST_OCA, CS_DIV1, ACT_TOGGLE, ACT_TOGGLE));
		gap(n);
		chk(n, 4);
		chk(wave_en_a, 1);
		chk(wave_en_b, 0);
		wr(ADDR_CTRL, cw(WGM_FAST_FF, CS_DIV1, ACT_TOGGLE, ACT_OFF));
		@(posedge clk_sys);
		#1 chk(wave_en_a, 0);
		// duty cycles are phase independent over whole periods
		for (int j = 0; j < 3; j++) begin
			wr(ADDR_CTRL, cw(WGM_FAST_FF, CS_DIV1, ACT_CLEAR, ACT_SET));
			wr(ADDR_CMP_A, {24'h0, cv[j]});
			wr(ADDR_CMP_B, 32'h0000_0080);
			repeat (600) @(posedge clk_sys);
			duty(512, ha, hb);
			chk(ha, fx[j]);
			chk(hb, 254);
			chk(wave_en_b, 1);
		end
		chk(match_flag_b, 1);
		for (int j = 2; j >= 0; j--) begin
			wr(ADDR_CTRL, cw(WGM_PC_FF, CS_DIV1, ACT_CLEAR, ACT_SET));
			wr(ADDR_CMP_A, {24'h0, cv[j]});
			repeat (1100) @(posedge clk_sys);
			duty(510, ha, hb);
			chk(ha, px[j]);
			chk(hb, 254);
		end
		chk(overflow_flag, 1);
		// clear-on-match with set and clear actions, both compare values at zero
		wr(ADDR_CTRL, cw(WGM_CTC, CS_DIV1, ACT_SET, ACT_CLEAR));
		wr(ADDR_CMP_A, 32'h0000_0000);
		wr(ADDR_CMP_B, 32'h0000_0000);
		repeat (300) @(posedge clk_sys);
		#1 chk(wave_out_a, 32'h0000_0001);
		chk(wave_out_b, 32'h0000_0000);
		chk(wave_en_b, 32'h0000_0001);
		// stopped timer: interrupt acknowledges clear every flag
		wr(ADDR_CTRL, CTRL_RESET);
		ack_all();
		chk(overflow_flag, 0);
		chk(match_flag_a, 0);
		chk(match_flag_b, 0);
		rd(ADDR_FLAGS, d);
		chk(d, 32'h0000_0000);
		tally_and_finish();
	end
endmodule : testbench
